//--- hdl/use_pkg.sv
// package of constants and types for the serial enable sequencing block
// ==========================================================
package use_pkg;
	localparam int          DIV_W       = 8;          // base clock divider width
	localparam int          BAUD_W      = 8;          // base ticks per bit counter width
	localparam int          DATA_W      = 8;          // character width, max
	localparam int          SYNC_TICKS  = 2;          // enable sync depth in base ticks
	localparam logic [3:0]  BIT_CNT_RST = 4'h0;       // bit counter reset value
	localparam logic [7:0]  DATA_RST    = 8'h00;      // data reset value

	// transmit and receive states
	typedef enum logic [1:0] {
		USE_IDLE  = 2'b00,                         // line idle
		USE_START = 2'b01,                         // start bit
		USE_DATA  = 2'b10,                         // data and parity bits
		USE_STOP  = 2'b11                          // stop bit(s)
	} use_state_t;

	// even parity of a byte masked to 7 or 8 bits
	function automatic logic use_parity(input logic [7:0] data, input logic len8);
		use_parity = ^{data[7] & len8, data[6:0]};
	endfunction : use_parity
endpackage : use_pkg

//--- hdl/use_buf2.sv
// two-entry skid buffer for received characters
`timescale 1ns/100ps
module use_buf2 #(
	parameter int W = 8                            // word width
) (
	input  wire logic         i_mclk,              // clock
	input  wire logic         i_arst_n,            // async reset, low
	input  wire logic         i_clr,               // flush both entries
	input  wire logic [W-1:0] i_data,              // write data
	input  wire logic         i_valid,             // write valid
	output logic              o_ready,             // space available
	output logic      [W-1:0] o_data,              // read data
	output logic              o_valid,             // read valid
	input  wire logic         i_ready              // consumer takes word
);
	import use_pkg::*;
	// ==========================================================
	// storage
	logic [W-1:0] mem_q [2];                       // entries
	logic [W-1:0] mem_d [2];                       // next entries
	logic         wp_q, wp_d, rp_q, rp_d;          // pointers
	logic [1:0]   cnt_q, cnt_d;                    // fill level
	logic         wr, rd;                          // accepted moves

	assign o_ready = (cnt_q != 2'd2);
	assign o_valid = (cnt_q != 2'd0);
	assign o_data  = mem_q[rp_q];                  // registered storage
	assign wr      = i_valid & o_ready;
	assign rd      = o_valid & i_ready;

	// next state of pointers and storage
	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (i_clr) begin
			wp_d  = 1'b0;
			rp_d  = 1'b0;
			cnt_d = 2'd0;
		end else begin
			if (wr) begin
				mem_d[wp_q] = i_data;
				wp_d        = ~wp_q;
			end
			if (rd) begin
				rp_d = ~rp_q;
			end
			cnt_d = 2'(cnt_q + {1'b0, wr} - {1'b0, rd});
		end
	end

	// register
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'd0;
		end else begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : use_buf2

//--- hdl/use_serial.sv
// serial transmitter/receiver with enable sequencing
`timescale 1ns/100ps
module use_serial (
	input  wire logic                     i_mclk,           // peripheral clock; stopping it freezes all
	input  wire logic                     i_arst_n,         // async reset, low
	input  wire logic                     i_serial_power_bit,    // block power
	input  wire logic                     i_transmit_enable_bit, // transmit enable
	input  wire logic                     i_receive_enable_bit,  // receive enable
	input  wire logic [use_pkg::DIV_W-1:0] i_baud_divider_control, // base tick period minus 1
	input  wire logic [use_pkg::BAUD_W-1:0] i_bit_ticks,    // base ticks per bit minus 1
	input  wire logic                     i_parity_select_hi,   // parity on
	input  wire logic                     i_parity_select_lo,   // odd when set
	input  wire logic                     i_char_length_select, // 1: 8 bits, 0: 7 bits
	input  wire logic                     i_stop_length_select, // 1: two transmit stop bits
	input  wire logic [7:0]               i_transmit_shift_reg, // transmit data
	input  wire logic                     i_tx_write,       // write strobe for transmit data
	output logic                          o_tx_write_ready, // transmitter can take a byte
	output logic                          o_serial_out_pin, // line out
	input  wire logic                     i_serial_in_pin,  // line in
	output logic [7:0]                    o_rx_data,        // received character
	output logic                          o_rx_valid,       // character available
	input  wire logic                     i_rx_ready,       // consumer takes character
	output logic                          o_rx_overrun,     // word lost, buffer full
	output logic                          o_rx_frame_err,   // stop bit low
	output logic                          o_rx_parity_err,  // parity mismatch
	output logic                          o_tx_done_interrupt // one pulse at end of frame
);
	import use_pkg::*;
	// ==========================================================
	// base clock divider and enable synchronisers
	logic [DIV_W-1:0] div_q, div_d;                // divider count
	logic             tick;                        // base clock tick
	logic [SYNC_TICKS-1:0] txs_q, txs_d, rxs_q, rxs_d; // enable sync chains
	logic             tx_en, rx_en;                // synced enables

	assign tick  = (div_q == '0);
	assign tx_en = txs_q[SYNC_TICKS-1];
	assign rx_en = rxs_q[SYNC_TICKS-1];

	// next divider and sync values; a cleared enable clears at once
	always_comb begin
		div_d = i_serial_power_bit ? (tick ? i_baud_divider_control : DIV_W'(div_q - 1'b1)) : '0;
		txs_d = txs_q;
		rxs_d = rxs_q;
		if (!(i_serial_power_bit & i_transmit_enable_bit)) begin
			txs_d = '0;
		end else if (tick) begin
			txs_d = {txs_q[SYNC_TICKS-2:0], 1'b1};
		end
		if (!(i_serial_power_bit & i_receive_enable_bit)) begin
			rxs_d = '0;
		end else if (tick) begin
			rxs_d = {rxs_q[SYNC_TICKS-2:0], 1'b1};
		end
	end

	// register; without clock edges all state holds
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_q <= '0;
			txs_q <= '0;
			rxs_q <= '0;
		end else begin
			div_q <= div_d;
			txs_q <= txs_d;
			rxs_q <= rxs_d;
		end
	end

	// ==========================================================
	// transmitter
	use_state_t       ts_q, ts_d;                  // transmit state
	logic [BAUD_W-1:0] tc_q, tc_d;                 // ticks in bit
	logic [3:0]       tb_q, tb_d;                  // bits left in phase
	logic [8:0]       tsh_q, tsh_d;                // shift with parity
	logic             tout_q, tout_d;              // line level register
	logic             tdone_q, tdone_d;            // done pulse
	logic             tbit_end;                    // end of a bit
	logic [3:0]       nbits;                       // data plus parity bits

	assign nbits    = 4'(7 + {3'b0, i_char_length_select} + {3'b0, i_parity_select_hi});
	assign tbit_end = tick & (tc_q == i_bit_ticks);
	assign o_tx_write_ready = tx_en & (ts_q == USE_IDLE);
	assign o_serial_out_pin = tout_q;
	assign o_tx_done_interrupt = tdone_q;

	// next transmit state
	always_comb begin
		ts_d    = ts_q;
		tc_d    = tc_q;
		tb_d    = tb_q;
		tsh_d   = tsh_q;
		tout_d  = tout_q;
		tdone_d = 1'b0;
		if (!tx_en) begin
			ts_d   = USE_IDLE;
			tout_d = 1'b1;
		end else begin
			if (tick) begin
				tc_d = tbit_end ? '0 : BAUD_W'(tc_q + 1'b1);
			end
			unique case (ts_q)
				USE_IDLE: begin
					tout_d = 1'b1;
					if (i_tx_write) begin
						tsh_d = {use_parity(i_transmit_shift_reg, i_char_length_select)
						         ^ i_parity_select_lo, i_transmit_shift_reg};
						if (!i_char_length_select) begin
							tsh_d[7] = tsh_d[8];
						end
						tc_d   = '0;
						tout_d = 1'b0;
						ts_d   = USE_START;
					end
				end
				USE_START: begin
					if (tbit_end) begin
						tb_d   = 4'(nbits - 1'b1);
						tout_d = tsh_q[0];
						tsh_d  = {1'b1, tsh_q[8:1]};
						ts_d   = USE_DATA;
					end
				end
				USE_DATA: begin
					if (tbit_end) begin
						if (tb_q == BIT_CNT_RST) begin
							tout_d = 1'b1;
							tb_d   = {3'b0, i_stop_length_select};
							ts_d   = USE_STOP;
						end else begin
							tout_d = tsh_q[0];
							tsh_d  = {1'b1, tsh_q[8:1]};
							tb_d   = 4'(tb_q - 1'b1);
						end
					end
				end
				USE_STOP: begin
					if (tbit_end) begin
						if (tb_q == BIT_CNT_RST) begin
							tdone_d = 1'b1;
							ts_d    = USE_IDLE;
						end else begin
							tb_d = 4'(tb_q - 1'b1);
						end
					end
				end
			endcase
		end
	end

	// register transmit state
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ts_q    <= USE_IDLE;
			tc_q    <= '0;
			tb_q    <= BIT_CNT_RST;
			tsh_q   <= '0;
			tout_q  <= 1'b1;
			tdone_q <= 1'b0;
		end else begin
			ts_q    <= ts_d;
			tc_q    <= tc_d;
			tb_q    <= tb_d;
			tsh_q   <= tsh_d;
			tout_q  <= tout_d;
			tdone_q <= tdone_d;
		end
	end

	// ==========================================================
	// receiver
	use_state_t        rs_q, rs_d;                 // receive state
	logic [BAUD_W-1:0] rc_q, rc_d;                 // ticks in bit
	logic [3:0]        rb_q, rb_d;                 // bits left
	logic [8:0]        rsh_q, rsh_d;               // shift in
	logic              rpush, bready;              // word to buffer
	logic [7:0]        rword;                      // assembled character
	logic              ovr_q, ovr_d, fe_q, fe_d, pe_q, pe_d; // error flags
	logic              rsample, rbit_end;          // mid and end of bit

	assign rsample  = tick & (rc_q == (i_bit_ticks >> 1));
	assign rbit_end = tick & (rc_q == i_bit_ticks);
	assign rword    = i_char_length_select ? rsh_q[7:0] : {1'b0, rsh_q[7:1]};
	assign o_rx_overrun    = ovr_q;
	assign o_rx_frame_err  = fe_q;
	assign o_rx_parity_err = pe_q;

	// next receive state; low input at enable starts reception at once
	always_comb begin
		rs_d  = rs_q;
		rc_d  = rc_q;
		rb_d  = rb_q;
		rsh_d = rsh_q;
		rpush = 1'b0;
		ovr_d = ovr_q;
		fe_d  = fe_q;
		pe_d  = pe_q;
		if (!rx_en) begin
			rs_d = USE_IDLE;
		end else begin
			if (tick) begin
				rc_d = rbit_end ? '0 : BAUD_W'(rc_q + 1'b1);
			end
			unique case (rs_q)
				USE_IDLE: begin
					if (!i_serial_in_pin) begin
						rc_d = '0;
						rs_d = USE_START;
					end
				end
				USE_START: begin
					if (rsample && i_serial_in_pin) begin
						rs_d = USE_IDLE;                              // glitch
					end else if (rbit_end) begin
						rb_d = 4'(nbits - 1'b1);
						rs_d = USE_DATA;
					end
				end
				USE_DATA: begin
					if (rsample) begin
						rsh_d = {i_serial_in_pin, rsh_q[8:1]};
					end
					if (rbit_end) begin
						if (rb_q == BIT_CNT_RST) begin
							if (!i_parity_select_hi) begin
								rsh_d = {1'b0, rsh_q[8:1]};
							end
							rs_d = USE_STOP;
						end else begin
							rb_d = 4'(rb_q - 1'b1);
						end
					end
				end
				USE_STOP: begin
					if (rsample) begin
						fe_d  = ~i_serial_in_pin;
						pe_d  = i_parity_select_hi &
						        (use_parity(rword, 1'b1) ^ rsh_q[8] ^ i_parity_select_lo);
						rpush = 1'b1;
						ovr_d = ~bready;
						rs_d  = USE_IDLE;
					end
				end
			endcase
		end
	end

	// register receive state
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rs_q  <= USE_IDLE;
			rc_q  <= '0;
			rb_q  <= BIT_CNT_RST;
			rsh_q <= '0;
			ovr_q <= 1'b0;
			fe_q  <= 1'b0;
			pe_q  <= 1'b0;
		end else begin
			rs_q  <= rs_d;
			rc_q  <= rc_d;
			rb_q  <= rb_d;
			rsh_q <= rsh_d;
			ovr_q <= ovr_d;
			fe_q  <= fe_d;
			pe_q  <= pe_d;
		end
	end

	// received word buffer; flushed when power is off
	use_buf2 #(
		.W (DATA_W)
	) u_buf (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_clr    (~i_serial_power_bit),
		.i_data   (rword),
		.i_valid  (rpush),
		.o_ready  (bready),
		.o_data   (o_rx_data),
		.o_valid  (o_rx_valid),
		.i_ready  (i_rx_ready)
	);
endmodule : use_serial

//--- testbench/use_serial_assertions.sv
// concurrent checks on the serial block ports
`timescale 1ns/100ps
module use_serial_chk (
	input wire logic       i_mclk,                // clock
	input wire logic       i_arst_n,              // async reset, low
	input wire logic       i_serial_power_bit,    // block power
	input wire logic       i_transmit_enable_bit, // transmit enable
	input wire logic       i_tx_write,            // transmit write strobe
	input wire logic       o_tx_write_ready,      // transmitter can take a byte
	input wire logic       o_serial_out_pin,      // line out
	input wire logic [7:0] o_rx_data,             // received character
	input wire logic       o_rx_valid,            // character available
	input wire logic       i_rx_ready,            // consumer takes character
	input wire logic       o_rx_overrun,          // word lost
	input wire logic       o_tx_done_interrupt    // end of frame pulse
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	wire logic take = i_tx_write && o_tx_write_ready; // accepted byte

	ready_off_a: assert property (!(i_serial_power_bit && i_transmit_enable_bit) |=> !o_tx_write_ready)
		else $error("ready while disabled");
	sync_gap_a: assert property ($rose(i_transmit_enable_bit) && i_serial_power_bit |->
		!o_tx_write_ready ##[1:8] o_tx_write_ready) else $error("enable sync timing wrong");
	start_bit_a: assert property (take |=> !o_serial_out_pin) else $error("no start bit");
	busy_a: assert property (take |=> !o_tx_write_ready [*8]) else $error("ready during frame");
	done_pulse_a: assert property (o_tx_done_interrupt |=> !o_tx_done_interrupt) else $error("done too long");
	done_stop_a: assert property (o_tx_done_interrupt |-> o_serial_out_pin && $past(o_serial_out_pin, 2))
		else $error("done before stop bit");
	idle_high_a: assert property (o_tx_write_ready |-> o_serial_out_pin) else $error("idle line low");
	flush_a: assert property (!i_serial_power_bit |=> !o_rx_valid) else $error("rx kept when off");
	rx_hold_a: assert property (o_rx_valid && !i_rx_ready && i_serial_power_bit |=>
		(o_rx_valid && $stable(o_rx_data)) || !i_serial_power_bit) else $error("rx word lost");

	take_c: cover property (take);
	over_c: cover property (o_rx_overrun);
	pop_c: cover property (o_rx_valid && i_rx_ready);
endmodule : use_serial_chk

bind use_serial use_serial_chk u_chk (.*);

//--- testbench/use_line_partner.sv
// remote line partner: drives the receive line, decodes the transmit line
`timescale 1ns/100ps
module use_line_partner (
	input  wire logic        i_mclk,  // clock
	input  wire logic        i_line,  // device output line
	input  wire logic [3:0]  i_bits,  // bits sampled after start
	input  wire logic [7:0]  i_bt,    // clock cycles per bit
	output logic             o_line,  // device input line
	output logic      [10:0] o_frame  // last decoded bits, lsb first
);
	// line idles high between frames
	initial begin
		o_line = 1'b1;
		o_frame = 11'h000;
	end
	// decoder: mid-bit sampling after the start edge
	always begin
		@(negedge i_line);
		o_frame = 11'h000;
		repeat (i_bt / 2) @(posedge i_mclk);
		for (int k = 0; k < i_bits; k++) begin
			repeat (i_bt) @(posedge i_mclk);
			@(negedge i_mclk);           // read where the line has settled
			o_frame[k] = i_line;
		end
	end
	// one frame: start, eight data bits lsb first, one stop bit
	task automatic send(input logic [7:0] d, input logic stop);
		o_line <= 1'b0;
		repeat (i_bt) @(posedge i_mclk);
		for (int k = 0; k < 8; k++) begin
			o_line <= d[k];
			repeat (i_bt) @(posedge i_mclk);
		end
		o_line <= stop;
		repeat (i_bt) @(posedge i_mclk);
		o_line <= 1'b1; // released line back high
		repeat (i_bt) @(posedge i_mclk);
	endtask : send
	// hold the receive line at one level, e.g. low across an enable
	task automatic hold_line(input logic v);
		o_line <= v;
	endtask : hold_line
endmodule : use_line_partner

//--- testbench/test_use_serial.sv
// self-checking bench for the serial enable sequencing block
`timescale 1ns/100ps
module test_use_serial;
	import use_pkg::*;
	logic        i_mclk, i_arst_n, run, pwr, ten, ren, phi, plo, len8, stop2, wr, rx_rdy, lvl;
	logic        rdy, so, si, rxv, ovr, ferr, perr, done;
	logic [7:0]  div, data, rxd, bt;
	logic [10:0] frm;
	logic [3:0]  nb;
	logic [4:0]  modes [4] = '{5'h08, 5'h05, 5'h0E, 5'h1D}; // div0, len8, parity, odd, stop2
	logic [7:0]  rx_set [3] = '{8'h5A, 8'hC3, 8'h81};
	int          t, c, n_errors = 0, n_checks = 0;

	use_serial dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_serial_power_bit(pwr),
		.i_transmit_enable_bit(ten), .i_receive_enable_bit(ren), .i_baud_divider_control(div),
		.i_bit_ticks(8'h03), .i_parity_select_hi(phi), .i_parity_select_lo(plo),
		.i_char_length_select(len8), .i_stop_length_select(stop2), .i_transmit_shift_reg(data),
		.i_tx_write(wr), .o_tx_write_ready(rdy), .o_serial_out_pin(so), .i_serial_in_pin(si),
		.o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rx_rdy), .o_rx_overrun(ovr),
		.o_rx_frame_err(ferr), .o_rx_parity_err(perr), .o_tx_done_interrupt(done));
	use_line_partner u_line (.i_mclk(i_mclk), .i_line(so), .i_bits(nb), .i_bt(bt),
		.o_line(si), .o_frame(frm));

	// clock halts while run is low
	initial begin
		i_mclk = 1'b0;
		forever #2 if (run) i_mclk = ~i_mclk;
	end

	task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run

	// bits after start: data, optional parity, stop
	function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic [2:0] m);
		int n;
		exp_frame = m[2] ? {3'h0, d} : {4'h0, d[6:0]};
		n = m[2] ? 8 : 7;
		if (m[1]) begin
			exp_frame[n] = ^exp_frame ^ m[0];
			n++;
		end
		exp_frame[n] = 1'b1;
	endfunction : exp_frame

	// send one byte, try a refused write mid-frame, wait for done
	task automatic tx(input logic [7:0] d, output int t);
		t = 0;
		do @(negedge i_mclk); while (rdy !== 1'b1 && ++t < 50); // write only after synced enable
		@(posedge i_mclk) {wr, data} <= {1'b1, d};
		@(posedge i_mclk) wr <= 1'b0;
		repeat (8) @(posedge i_mclk);
		{wr, data} <= {1'b1, ~d};
		@(posedge i_mclk) wr <= 1'b0;
		t = 9;
		do @(negedge i_mclk); while (done !== 1'b1 && ++t < 900); // next byte only after done
	endtask : tx

	// watchdog
	initial begin
		#40000;
		n_errors++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial begin
		{run, i_arst_n, pwr, ten, ren, phi, plo, len8, stop2, wr, rx_rdy} = 11'h400;
		div = 8'h00; data = 8'h00; nb = 4'hA; bt = 8'h04;
		repeat (6) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		pwr <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge i_mclk) ten <= 1'b0;
			@(posedge i_mclk) {div[0], len8, phi, plo, stop2} <= modes[i]; // format set with enables low
			bt = modes[i][4] ? 8'h08 : 8'h04;
			nb = 4'(9 - !modes[i][3] + modes[i][2]);
			c = bt * (nb + 1 + modes[i][0]);
			repeat (5) @(posedge i_mclk); // re-enable gap of five clock cycles
			ten <= 1'b1; // power already on
			tx(8'(8'hA6 ^ i), t);
			check("frame", frm, exp_frame(8'(8'hA6 ^ i), modes[i][3:1]));
			check("time", 11'(t > c - 5 && t < c + 5), 11'h001);
		end
		$display("transmit modes done");
		fork
			tx(8'h96, t);
			begin
				repeat (20) @(negedge i_mclk);
				run = 1'b0;
				lvl = so;
				#100 check("hold", so, lvl);
				run = 1'b1;
			end
		join
		check("resume", frm, exp_frame(8'h96, modes[3][3:1]));
		check("resume time", 11'(t > c - 5 && t < c + 5), 11'h001);
		@(posedge i_mclk) ten <= 1'b0; // transmit off before power
		@(posedge i_mclk) pwr <= 1'b0; // known state after restart
		@(posedge i_mclk) {pwr, div[0], len8, phi, plo, stop2} <= 6'h29;
		bt = 8'h04;
		repeat (2) @(posedge i_mclk);
		ren <= 1'b1;
		repeat (4) @(posedge i_mclk);
		foreach (rx_set[k]) u_line.send(rx_set[k], 1'b1);
		@(negedge i_mclk) check("overrun", ovr, 11'h001);
		for (int k = 0; k < 2; k++) begin
			@(negedge i_mclk) check("rxd", rxd, rx_set[k]);
			@(posedge i_mclk) rx_rdy <= 1'b1;
			@(posedge i_mclk) rx_rdy <= 1'b0;
		end
		@(negedge i_mclk) check("empty", rxv, 11'h000);
		u_line.send(8'h77, 1'b0);
		@(negedge i_mclk) check("stop low", {ovr, perr, ferr}, 11'h001);
		u_line.send(8'h0F, 1'b1);
		@(negedge i_mclk) check("stop ok", {perr, ferr}, 11'h000);
		@(posedge i_mclk) ren <= 1'b0;
		@(posedge i_mclk) {len8, phi} <= 2'b01; // seven bits, even parity, enables low
		repeat (2) @(posedge i_mclk);
		ren <= 1'b1; // power already on
		repeat (4) @(posedge i_mclk);
		u_line.send(8'h83, 1'b1); // top bit acts as a wrong parity bit
		@(negedge i_mclk) check("parity bad", {ovr, perr, ferr}, 11'h006);
		u_line.send(8'h03, 1'b1); // top bit acts as a right parity bit
		@(negedge i_mclk) check("parity ok", {ovr, perr, ferr}, 11'h004);
		@(posedge i_mclk) ren <= 1'b0;
		@(posedge i_mclk) pwr <= 1'b0;
		repeat (2) @(negedge i_mclk);
		check("flush", rxv, 11'h000);
		@(posedge i_mclk) pwr <= 1'b1;
		u_line.hold_line(1'b0);
		repeat (2) @(posedge i_mclk);
		ren <= 1'b1;
		repeat (38) @(posedge i_mclk);
		u_line.hold_line(1'b1);
		repeat (8) @(posedge i_mclk);
		@(negedge i_mclk) check("low start", {rxv, rxd[6:0]}, 11'h080);
		$display("receive tests done");
		complete_run();
	end
endmodule : test_use_serial
